//--- verilog/ser_defines.svh
// bit positions, reset values and sizes of the status event reporting block
`ifndef SER_DEFINES_SVH
`define SER_DEFINES_SVH

// ----------------------------------------------------------------------------
// event status flag positions
// ----------------------------------------------------------------------------
`define SER_ESR_OPC        0
`define SER_ESR_QUERY_ERR  2
`define SER_ESR_DEV_ERR    3
`define SER_ESR_EXEC_ERR   4
`define SER_ESR_CMD_ERR    5
`define SER_ESR_USER_REQ   6
`define SER_ESR_POWER_ON   7
`define SER_ESR_USED       8'hfd
`define SER_ESR_RESET      8'h80

// ----------------------------------------------------------------------------
// operation / questionable state flags
// ----------------------------------------------------------------------------
`define SER_OPER_CAL       0
`define SER_OPER_SWEEP     3
`define SER_OPER_USED      16'h0009
`define SER_QUES_VALUE     16'h0000

// ----------------------------------------------------------------------------
// status byte positions
// ----------------------------------------------------------------------------
`define SER_STB_ERR_AVAIL  2
`define SER_STB_QUES_SUM   3
`define SER_STB_MSG_AVAIL  4
`define SER_STB_EVENT_SUM  5
`define SER_STB_REQ_SUM    6
`define SER_STB_OPER_SUM   7
`define SER_STB_SRQ_BITS   8'h34

// ----------------------------------------------------------------------------
// error queue
// ----------------------------------------------------------------------------
`define SER_EQ_DEPTH       8
`define SER_EQ_AW          3
`define SER_NO_ERROR       16'h0000

`endif

//--- verilog/ser_pkg.sv
// types shared by the status event reporting block
`include "ser_defines.svh"

package ser_pkg;

  // controller commands reaching the status system
  typedef enum logic [3:0] {
    SER_CMD_NONE       = 4'h0,
    SER_CMD_READ_ESR   = 4'h1,
    SER_CMD_WRITE_ESE  = 4'h2,
    SER_CMD_READ_ESE   = 4'h3,
    SER_CMD_READ_STB   = 4'h4,
    SER_CMD_WRITE_SRE  = 4'h5,
    SER_CMD_READ_SRE   = 4'h6,
    SER_CMD_QUES_COND  = 4'h7,
    SER_CMD_QUES_EVEN  = 4'h8,
    SER_CMD_OPER_COND  = 4'h9,
    SER_CMD_OPER_EVEN  = 4'ha,
    SER_CMD_WRITE_OENA = 4'hb,
    SER_CMD_READ_OENA  = 4'hc,
    SER_CMD_READ_ERR   = 4'hd,
    SER_CMD_CLEAR      = 4'he,
    SER_CMD_OPC        = 4'hf
  } ser_cmd_t;

  // error classes reported by the command processor
  typedef enum logic [1:0] {
    SER_ERR_DEVICE  = 2'h0,
    SER_ERR_EXEC    = 2'h1,
    SER_ERR_COMMAND = 2'h2
  } ser_err_class_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0]                          event_status_flags;
    logic [7:0]                          event_status_enable_mask;
    logic [7:0]                          service_request_enable_mask;
    logic [15:0]                         oper_cond;
    logic [15:0]                         operation_state_flags;
    logic [15:0]                         oper_enable;
    logic                                opc_pending;
    logic                                rsp_valid;
    logic [15:0]                         rsp_data;
    logic                                rsp_no_error;
    logic                                spoll_valid;
    logic [7:0]                          spoll_data;
    logic [7:0]                          status_byte;
    logic                                srq;
    logic [`SER_EQ_DEPTH-1:0][15:0]      eq;
    logic [`SER_EQ_AW-1:0]               eq_wr;
    logic [`SER_EQ_AW-1:0]               eq_rd;
    logic [`SER_EQ_AW:0]                 eq_count;
  } ser_state_t;

endpackage

//--- verilog/ser_status.sv
// status event reporting: event flags, operation flags, status byte, error queue
//
// Summary of operation
// - event flag rising with its enable bit set raises the event summary bit
// - flag 0 set after operation-complete command once all earlier commands finished
// - flag 2 set on read without query or new command over unread answer
// - flag 3 set on device error; its error code is queued
// - flag 4 set on execution error; its error code is queued
// - flag 5 set on command error; its error code is queued
// - flag 6 set when the instrument goes from remote to local control
// - flag 7 set at power on; flag 1 unused
// - enable mask written and read by command; event flags read by query
// - questionable flags have sixteen positions, none ever reported
// - operation condition shows actions now; event part records them since last read
// - operation bit 0 high throughout calibration
// - operation bit 3 high during any sweep; other bits unused
// - service request raised when status byte bit 2, 4 or 5 set and enabled
// - serial poll returns the same status byte as the status byte query
// - every register query answers with the register's current bit pattern
// - each error appends one entry unless eight are held after that cycle's error read; each error read of a non-empty queue removes exactly one
// - error read on empty queue returns code 0 with no-error indication
// - summary bit is OR over all positions of event AND enable
// - request enable bit 6 has no effect on request generation
`timescale 1ns/1ps
`include "ser_defines.svh"

module ser_status (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // command port from the remote command parser
  input  wire logic                  cmd_valid,
  input  wire ser_pkg::ser_cmd_t     cmd_code,
  input  wire logic [15:0]           cmd_data,
  input  wire logic                  read_req,
  output logic                       rsp_valid,
  output logic [15:0]                rsp_data,
  output logic                       rsp_no_error,
  // serial poll
  input  wire logic                  spoll_req,
  output logic                       spoll_valid,
  output logic [7:0]                 spoll_data,
  // instrument events
  input  wire logic                  exec_idle,
  input  wire logic                  err_valid,
  input  wire ser_pkg::ser_err_class_t err_class,
  input  wire logic [15:0]           err_code,
  input  wire logic                  go_local,
  input  wire logic                  calibrating,
  input  wire logic                  sweeping,
  input  wire logic                  msg_available,
  // status outputs
  output logic [7:0]                 status_byte,
  output logic                       service_request
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------

  // summary of an event part through its enable part
  function automatic logic summary8(input logic [7:0] ev, input logic [7:0] en);
    summary8 = |(ev & en);
  endfunction

  function automatic logic summary16(input logic [15:0] ev, input logic [15:0] en);
    summary16 = |(ev & en);
  endfunction

  ser_pkg::ser_state_t state_reg;
  ser_pkg::ser_state_t state_next;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------

  // one pass: answers and clears first, then hardware sets, so a set wins
  always_comb begin
    logic [15:0]            oper_now;
    logic                   pop;
    logic                   push;
    logic [`SER_EQ_AW:0]    cnt;
    logic [7:0]             stb;
    oper_now   = 16'h0000;
    pop        = 1'b0;
    push       = 1'b0;
    cnt        = 4'h0;
    stb        = 8'h00;
    state_next = state_reg;
    state_next.spoll_valid = 1'b0;

    // controller collects the held answer; reading with none is a query error
    if (read_req) begin
      if (state_reg.rsp_valid) begin
        state_next.rsp_valid = 1'b0;
      end
    end

    // command handling
    if (cmd_valid) begin
      state_next.rsp_valid    = 1'b0; // an uncollected answer is dropped
      state_next.rsp_no_error = 1'b0;
      unique case (cmd_code)
        ser_pkg::SER_CMD_READ_ESR: begin
          state_next.rsp_valid          = 1'b1;
          state_next.rsp_data           = {8'h00, state_reg.event_status_flags};
          state_next.event_status_flags = 8'h00; // reading clears the event part
        end
        ser_pkg::SER_CMD_WRITE_ESE: begin
          state_next.event_status_enable_mask = cmd_data[7:0];
        end
        ser_pkg::SER_CMD_READ_ESE: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = {8'h00, state_reg.event_status_enable_mask};
        end
        ser_pkg::SER_CMD_READ_STB: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = {8'h00, state_reg.status_byte};
        end
        ser_pkg::SER_CMD_WRITE_SRE: begin
          state_next.service_request_enable_mask = cmd_data[7:0];
        end
        ser_pkg::SER_CMD_READ_SRE: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = {8'h00, state_reg.service_request_enable_mask};
        end
        ser_pkg::SER_CMD_QUES_COND,
        ser_pkg::SER_CMD_QUES_EVEN: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = `SER_QUES_VALUE;
        end
        ser_pkg::SER_CMD_OPER_COND: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = state_reg.oper_cond;
        end
        ser_pkg::SER_CMD_OPER_EVEN: begin
          state_next.rsp_valid             = 1'b1;
          state_next.rsp_data              = state_reg.operation_state_flags;
          state_next.operation_state_flags = 16'h0000;
        end
        ser_pkg::SER_CMD_WRITE_OENA: begin
          state_next.oper_enable = cmd_data;
        end
        ser_pkg::SER_CMD_READ_OENA: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = state_reg.oper_enable;
        end
        ser_pkg::SER_CMD_READ_ERR: begin
          state_next.rsp_valid = 1'b1;
          if (state_reg.eq_count != 4'h0) begin
            state_next.rsp_data = state_reg.eq[state_reg.eq_rd];
            pop                 = 1'b1;
          end else begin
            state_next.rsp_data     = `SER_NO_ERROR;
            state_next.rsp_no_error = 1'b1;
          end
        end
        ser_pkg::SER_CMD_CLEAR: begin
          state_next.event_status_flags    = 8'h00;
          state_next.operation_state_flags = 16'h0000;
          state_next.eq_wr                 = 3'h0;
          state_next.eq_rd                 = 3'h0;
          state_next.eq_count              = 4'h0;
          state_next.opc_pending           = 1'b0;
        end
        ser_pkg::SER_CMD_OPC: begin
          state_next.opc_pending = 1'b1;
        end
        default: begin
          state_next.rsp_valid = state_reg.rsp_valid & ~read_req;
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // hardware sets, after every clear above
    // ------------------------------------------------------------------------

    // query error: read with nothing held, or new command over an unread answer
    if ((read_req && !state_reg.rsp_valid) ||
        (cmd_valid && state_reg.rsp_valid && !read_req)) begin
      state_next.event_status_flags[`SER_ESR_QUERY_ERR] = 1'b1;
    end

    // operation complete once all earlier commands have finished
    if (state_next.opc_pending && exec_idle) begin
      state_next.event_status_flags[`SER_ESR_OPC] = 1'b1;
      state_next.opc_pending                      = 1'b0;
    end

    // error classes set their flag and queue the code
    if (err_valid) begin
      push = 1'b1;
      unique case (err_class)
        ser_pkg::SER_ERR_DEVICE:
          state_next.event_status_flags[`SER_ESR_DEV_ERR] = 1'b1;
        ser_pkg::SER_ERR_EXEC:
          state_next.event_status_flags[`SER_ESR_EXEC_ERR] = 1'b1;
        ser_pkg::SER_ERR_COMMAND:
          state_next.event_status_flags[`SER_ESR_CMD_ERR] = 1'b1;
        default:
          state_next.event_status_flags[`SER_ESR_DEV_ERR] = 1'b1;
      endcase
    end

    // remote to local changeover
    if (go_local) begin
      state_next.event_status_flags[`SER_ESR_USER_REQ] = 1'b1;
    end

    // error queue: pop then push; a full queue drops the newest error
    cnt = state_next.eq_count;
    if (pop) begin
      state_next.eq_rd = state_reg.eq_rd + 3'h1;
      cnt              = cnt - 4'h1;
    end
    if (push && (cnt != `SER_EQ_DEPTH)) begin
      state_next.eq[state_next.eq_wr] = err_code;
      state_next.eq_wr                = state_next.eq_wr + 3'h1;
      cnt                             = cnt + 4'h1;
    end
    state_next.eq_count = cnt;

    // operation condition follows the instrument, event part latches rises
    oper_now[`SER_OPER_CAL]   = calibrating;
    oper_now[`SER_OPER_SWEEP] = sweeping;
    oper_now                  = oper_now & `SER_OPER_USED;
    state_next.oper_cond      = oper_now;
    state_next.operation_state_flags = state_next.operation_state_flags
                                     | (oper_now & ~state_reg.oper_cond);

    // unused event flag positions never hold a one
    state_next.event_status_flags = state_next.event_status_flags & `SER_ESR_USED;

    // status byte built from the next state so it tracks without lag
    stb[`SER_STB_ERR_AVAIL] = (cnt != 4'h0);
    stb[`SER_STB_QUES_SUM]  = summary16(`SER_QUES_VALUE, 16'hffff);
    stb[`SER_STB_MSG_AVAIL] = msg_available;
    stb[`SER_STB_EVENT_SUM] = summary8(state_next.event_status_flags,
                                       state_next.event_status_enable_mask);
    stb[`SER_STB_OPER_SUM]  = summary16(state_next.operation_state_flags,
                                        state_next.oper_enable);
    // enable bit 6 is masked out since that position is the summary itself
    state_next.srq = summary8(stb, state_next.service_request_enable_mask
                                   & `SER_STB_SRQ_BITS);
    stb[`SER_STB_REQ_SUM]  = state_next.srq;
    state_next.status_byte = stb;

    // serial poll shows the same byte as the status byte query
    if (spoll_req) begin
      state_next.spoll_valid = 1'b1;
      state_next.spoll_data  = state_reg.status_byte;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------

  // reset stands for power on, hence the power-on flag comes up set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg                    <= '0;
      state_reg.event_status_flags <= `SER_ESR_RESET;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign rsp_valid       = state_reg.rsp_valid;
  assign rsp_data        = state_reg.rsp_data;
  assign rsp_no_error    = state_reg.rsp_no_error;
  assign spoll_valid     = state_reg.spoll_valid;
  assign spoll_data      = state_reg.spoll_data;
  assign status_byte     = state_reg.status_byte;
  assign service_request = state_reg.srq;

endmodule // ser_status

//--- verification/ser_status_checker.sv
// assertions on the status event reporting ports
`timescale 1ns/1ps
module ser_status_checker (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic              cmd_valid,
  input wire ser_pkg::ser_cmd_t cmd_code,
  input wire logic              read_req,
  input wire logic              rsp_valid,
  input wire logic [15:0]       rsp_data,
  input wire logic              rsp_no_error,
  input wire logic              spoll_req,
  input wire logic              spoll_valid,
  input wire logic [7:0]        spoll_data,
  input wire logic              err_valid,
  input wire logic [7:0]        status_byte,
  input wire logic              service_request
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // event flag and enable reads answer next cycle with a clear upper byte
  rd_answer_a: assert property (ce && cmd_valid && cmd_code inside
    {ser_pkg::SER_CMD_READ_ESR, ser_pkg::SER_CMD_READ_ESE, ser_pkg::SER_CMD_READ_SRE}
    |=> rsp_valid && rsp_data[15:8] == 8'h00) else $error("read gave no clean answer");
  mask_write_a: assert property (
    ce && cmd_valid && cmd_code == ser_pkg::SER_CMD_WRITE_ESE |=> !rsp_valid)
    else $error("mask write produced an answer");
  answer_taken_a: assert property (ce && read_req && !cmd_valid |=> !rsp_valid)
    else $error("answer still held after collection");
  ques_zero_a: assert property (ce && cmd_valid && cmd_code inside
    {ser_pkg::SER_CMD_QUES_COND, ser_pkg::SER_CMD_QUES_EVEN} |=> rsp_data == 16'h0000)
    else $error("questionable register not zero");
  empty_code_a: assert property (rsp_no_error |-> rsp_data == 16'h0000)
    else $error("empty queue answer not zero");

  // serial poll: one pulse carrying the byte seen at the request
  poll_copy_a: assert property (
    ce && spoll_req |=> spoll_valid && spoll_data == $past(status_byte))
    else $error("serial poll byte wrong");
  poll_idle_a: assert property (ce && !spoll_req |=> !spoll_valid)
    else $error("serial poll pulse without request");

  // request needs a cause in bits 2, 4 or 5; bit 6 alone never counts
  srq_cause_a: assert property (
    service_request |-> (status_byte & 8'h34) != 8'h00 && status_byte[6])
    else $error("service request without cause");
  err_avail_a: assert property (ce && err_valid |=> status_byte[2])
    else $error("error entry not flagged in status byte");
endmodule // ser_status_checker

//--- verification/ser_ctrl_model.sv
// remote controller model: issues serial polls and keeps the polled byte
`timescale 1ns/1ps
module ser_ctrl_model (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        poll_go,
  input wire logic        spoll_valid,
  input wire logic [7:0]  spoll_data,
  output logic            spoll_req,
  output logic [7:0]      poll_byte
);
  // request follows poll_go one cycle later; the answer is taken on its pulse only
  always_ff @(posedge core_clk) begin
    spoll_req <= poll_go && !rst;
    if (spoll_valid) begin
      poll_byte <= spoll_data;
    end
  end
endmodule // ser_ctrl_model

//--- verification/test_ser_status.sv
// self-checking bench for the status event reporting block
`timescale 1ns/1ps
module test_ser_status;
  logic                    core_clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    ce = 1'b1;
  logic                    cmd_valid = 1'b0;
  ser_pkg::ser_cmd_t       cmd_code = ser_pkg::SER_CMD_NONE;
  logic [15:0]             cmd_data = 16'h0000;
  logic                    read_req = 1'b0;
  logic                    exec_idle = 1'b1;
  logic                    err_valid = 1'b0;
  ser_pkg::ser_err_class_t err_class = ser_pkg::SER_ERR_DEVICE;
  logic [15:0]             err_code = 16'h0000;
  logic                    go_local = 1'b0;
  logic                    calibrating = 1'b0;
  logic                    sweeping = 1'b0;
  logic                    msg_available = 1'b0;
  logic                    poll_go = 1'b0;
  logic                    spoll_req, rsp_valid, rsp_no_error, spoll_valid, service_request;
  logic [15:0]             rsp_data;
  logic [7:0]              spoll_data, status_byte, poll_byte;
  logic [15:0]             codes [3] = '{16'hfea2, 16'hff22, 16'hff8f};
  int                      failures = 0;
  int                      checked = 0;

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  ser_status ser_status_i (.core_clk(core_clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .read_req(read_req), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_no_error(rsp_no_error), .spoll_req(spoll_req),
    .spoll_valid(spoll_valid), .spoll_data(spoll_data), .exec_idle(exec_idle),
    .err_valid(err_valid), .err_class(err_class), .err_code(err_code), .go_local(go_local),
    .calibrating(calibrating), .sweeping(sweeping), .msg_available(msg_available),
    .status_byte(status_byte), .service_request(service_request));
  ser_ctrl_model ser_ctrl_model_i (.core_clk(core_clk), .rst(rst), .poll_go(poll_go),
    .spoll_valid(spoll_valid), .spoll_data(spoll_data), .spoll_req(spoll_req),
    .poll_byte(poll_byte));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input ser_pkg::ser_cmd_t c, input logic [15:0] d);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic collect();
    @(posedge core_clk);
    read_req <= 1'b1;
    @(posedge core_clk);
    read_req <= 1'b0;
  endtask
  // bit 16 is the no-error mark for queue reads, the missing-answer mark otherwise
  task automatic q(input ser_pkg::ser_cmd_t c, input logic [16:0] exp);
    cmd(c, 16'h0000);
    @(negedge core_clk);
    chk("answer", {(c == ser_pkg::SER_CMD_READ_ERR) ? rsp_no_error : !rsp_valid, rsp_data}, exp);
    collect();
  endtask
  task automatic stb(input logic [7:0] exp);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("status byte", {1'b0, service_request, status_byte}, {1'b0, exp[6], exp});
  endtask
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    q(ser_pkg::SER_CMD_READ_ESR, 17'h00080);
    q(ser_pkg::SER_CMD_READ_ESR, 17'h00000);
    cmd(ser_pkg::SER_CMD_WRITE_ESE, 16'h00ff);
    cmd(ser_pkg::SER_CMD_WRITE_SRE, 16'h00bf);
    q(ser_pkg::SER_CMD_READ_ESE, 17'h000ff);
    q(ser_pkg::SER_CMD_READ_SRE, 17'h000bf);
    // one error of each class, each flagged and summarised
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      err_valid <= 1'b1;
      err_class <= ser_pkg::ser_err_class_t'(k);
      err_code <= codes[k];
      @(posedge core_clk);
      err_valid <= 1'b0;
      stb(8'h64);
      q(ser_pkg::SER_CMD_READ_ESR, 17'h00008 << k);
    end
    @(posedge core_clk);
    poll_go <= 1'b1;
    @(posedge core_clk);
    poll_go <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("poll", {9'h000, poll_byte}, 17'h00044);
    // queue drained in arrival order after the request
    for (int k = 0; k < 3; k++) begin
      q(ser_pkg::SER_CMD_READ_ERR, {1'b0, codes[k]});
    end
    q(ser_pkg::SER_CMD_READ_ERR, 17'h10000);
    stb(8'h00);
    collect();
    q(ser_pkg::SER_CMD_READ_ESR, 17'h00004);
    cmd(ser_pkg::SER_CMD_READ_SRE, 16'h0000);
    q(ser_pkg::SER_CMD_READ_ESE, 17'h000ff);
    q(ser_pkg::SER_CMD_READ_ESR, 17'h00004);
    @(posedge core_clk);
    go_local <= 1'b1;
    @(posedge core_clk);
    go_local <= 1'b0;
    q(ser_pkg::SER_CMD_READ_ESR, 17'h00040);
    // completion waits for the executor to go idle
    exec_idle <= 1'b0;
    cmd(ser_pkg::SER_CMD_OPC, 16'h0000);
    repeat (4) @(posedge core_clk);
    q(ser_pkg::SER_CMD_READ_ESR, 17'h00000);
    exec_idle <= 1'b1;
    repeat (2) @(posedge core_clk);
    q(ser_pkg::SER_CMD_READ_ESR, 17'h00001);
    cmd(ser_pkg::SER_CMD_WRITE_ESE, 16'h0001);
    cmd(ser_pkg::SER_CMD_WRITE_SRE, 16'h0040);
    cmd(ser_pkg::SER_CMD_OPC, 16'h0000);
    stb(8'h20);
    cmd(ser_pkg::SER_CMD_WRITE_SRE, 16'h0020);
    stb(8'h60);
    cmd(ser_pkg::SER_CMD_WRITE_ESE, 16'h0000);
    stb(8'h00);
    cmd(ser_pkg::SER_CMD_CLEAR, 16'h0000);
    // operation condition and event parts
    calibrating <= 1'b1;
    repeat (2) @(posedge core_clk);
    q(ser_pkg::SER_CMD_OPER_COND, 17'h00001);
    calibrating <= 1'b0;
    sweeping <= 1'b1;
    repeat (2) @(posedge core_clk);
    q(ser_pkg::SER_CMD_OPER_COND, 17'h00008);
    sweeping <= 1'b0;
    q(ser_pkg::SER_CMD_OPER_EVEN, 17'h00009);
    q(ser_pkg::SER_CMD_OPER_EVEN, 17'h00000);
    q(ser_pkg::SER_CMD_QUES_COND, 17'h00000);
    q(ser_pkg::SER_CMD_QUES_EVEN, 17'h00000);
    // operation summary reaches status byte bit 7 only through its enable
    cmd(ser_pkg::SER_CMD_WRITE_OENA, 16'h0009);
    q(ser_pkg::SER_CMD_READ_OENA, 17'h00009);
    calibrating <= 1'b1;
    stb(8'h80);
    @(posedge core_clk);
    calibrating <= 1'b0;
    q(ser_pkg::SER_CMD_OPER_EVEN, 17'h00001);
    msg_available <= 1'b1;
    stb(8'h10);
    q(ser_pkg::SER_CMD_READ_STB, 17'h00010);
    // a frozen block misses an event pulse entirely
    ce <= 1'b0;
    go_local <= 1'b1;
    @(posedge core_clk);
    go_local <= 1'b0;
    ce <= 1'b1;
    q(ser_pkg::SER_CMD_READ_ESR, 17'h00000);
    end_sim();
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    end_sim();
  end
endmodule // test_ser_status

bind ser_status ser_status_checker ser_status_checker_i (.core_clk(core_clk), .rst(rst),
  .ce(ce), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .read_req(read_req),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_no_error(rsp_no_error),
  .spoll_req(spoll_req), .spoll_valid(spoll_valid), .spoll_data(spoll_data),
  .err_valid(err_valid), .status_byte(status_byte), .service_request(service_request));
